// *** inc/bslr_pkg.sv ***
// Constants and carriers for the bay strap, latch and reset logic
// Summary of operation
// - Interrupt output goes low on a bay status change or removal request.
// - Host writes one to a status bit to clear it; interrupt then releases.
// - Slave address is 1001_0 followed by the two address strap pins.
// - Every reset samples the default strap and qualifies it with the mode strap.
// - Mode strap high: every latch control bit resets to zero.
// - Mode strap low: latch control bits reset to the sampled default strap.
// - Mode strap low: each latch drive output follows its control bit.
// - Mode strap high: control bit falling 1 to 0 fires one drive pulse.
// - Reset pin is deglitched; two clock pulses high reset all registers.
// - In pulse mode the drive output is pulled low during the pulse.
// - Timing register selects pulse length: 120 ms, 500 ms, 1 s or 2 s.
// - Removal request inputs are debounced before raising an interrupt.
package bslr_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int DEB_TICKS = 8;
	localparam int AW = 4;
	localparam int DW = 8;
	localparam int NBAYS = 2;
	localparam int CNT_W = 11;
	localparam int NEV = 4;
	localparam logic [AW-1:0] REG_STATUS = 4'h0;
	localparam logic [AW-1:0] REG_MASK = 4'h1;
	localparam logic [AW-1:0] REG_CONTROL = 4'h2;
	localparam logic [AW-1:0] REG_TIMING = 4'h3;
	localparam logic [AW-1:0] REG_INFO = 4'h4;
	localparam int EV_CHG_LSB = 0;
	localparam int EV_REM_LSB = 2;
	localparam logic [NEV-1:0] MASK_RST = 4'hf;
	localparam logic [1:0] TIMING_RST = 2'h0;
	localparam logic [4:0] ADDR_HI = 5'h12;
	localparam logic [CNT_W-1:0] PULSE_MS_0 = 11'h078;
	localparam logic [CNT_W-1:0] PULSE_MS_1 = 11'h1f4;
	localparam logic [CNT_W-1:0] PULSE_MS_2 = 11'h3e8;
	localparam logic [CNT_W-1:0] PULSE_MS_3 = 11'h7d0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} bslr_bus_req_type;

	typedef struct packed {
		logic rst;
		logic mode;
		logic def;
		logic [1:0] addr;
		logic [NBAYS-1:0] rem_n;
	} bslr_pins_type;

	// Pulse length in millisecond ticks
	function automatic logic [CNT_W-1:0] bslr_pulse_ticks(input logic [1:0] sel);
		logic [CNT_W-1:0] t;
		unique case (sel)
			2'h0: t = PULSE_MS_0;
			2'h1: t = PULSE_MS_1;
			2'h2: t = PULSE_MS_2;
			2'h3: t = PULSE_MS_3;
		endcase
		return t;
	endfunction
endpackage

// *** core/bslr_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module bslr_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import bslr_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bslr_sync_state_type;

	bslr_sync_state_type st;
	bslr_sync_state_type next_st;

	// No reset: the reset pin itself passes through here
	always_comb begin
		next_st = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	assign q = st.s2;
endmodule
`default_nettype wire

// *** core/bslr_debounce.sv ***
// Debouncer for the active-low removal request inputs
`timescale 1ns/100ps
`default_nettype none
module bslr_debounce #(
	parameter int TICKS = bslr_pkg::DEB_TICKS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic din,
	output logic dout
);
	import bslr_pkg::*;

	localparam int CW = $clog2(TICKS + 1);

	typedef struct packed {
		logic level;
		logic [CW-1:0] cnt;
	} bslr_deb_state_type;

	bslr_deb_state_type st;
	bslr_deb_state_type next_st;

	// New level must be seen on TICKS ticks in a row; any bounce restarts
	always_comb begin
		next_st = st;
		if (din == st.level) begin
			next_st.cnt = '0;
		end else if (tick) begin
			if (st.cnt == CW'(TICKS - 1)) begin
				next_st.level = din;
				next_st.cnt = '0;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
		if (rst) begin
			next_st.level = 1'b1;
			next_st.cnt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	assign dout = st.level;
endmodule
`default_nettype wire

// *** core/bslr_top.sv ***
// Strap decode, latch drive, interrupt and reset deglitch for two bays
`timescale 1ns/100ps
`default_nettype none
module bslr_top #(
	parameter int TICK_CYCLES = bslr_pkg::TICK_CYCLES,
	parameter int DEB_TICKS = bslr_pkg::DEB_TICKS
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire bslr_pkg::bslr_bus_req_type bus_req,
	output logic [bslr_pkg::DW-1:0] rdata,
	input wire logic [1:0] address_strap_pins,
	input wire logic latch_default_strap,
	input wire logic latch_mode_strap,
	input wire logic [bslr_pkg::NBAYS-1:0] removal_request_in_n,
	input wire logic [bslr_pkg::NBAYS-1:0] bay_event_in,
	output logic [bslr_pkg::NBAYS-1:0] latch_drive_out,
	output logic [bslr_pkg::NBAYS-1:0] latch_drive_oe,
	output logic irq_n,
	output logic [6:0] slave_address
);
	import bslr_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic rst_prev;
		logic rst_q;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [NBAYS-1:0] ctl;
		logic [NBAYS-1:0] ctl_prev;
		logic [NEV-1:0] status;
		logic [NEV-1:0] mask;
		logic [1:0] timing;
		logic [NBAYS-1:0][CNT_W-1:0] pulse_cnt;
		logic [NBAYS-1:0] rem_prev;
		logic [NBAYS-1:0] drive_oe;
		logic [NBAYS-1:0] drive_out;
		logic irq_n;
		logic [DW-1:0] rdata;
		logic [6:0] slave_addr;
	} bslr_state_type;

	bslr_state_type st;
	bslr_state_type next_st;
	bslr_pins_type pins_raw;
	bslr_pins_type pins;
	logic [NBAYS-1:0] rem_db;
	logic [NBAYS-1:0] rem_fall;
	logic [NBAYS-1:0] ctl_reset;

	assign pins_raw = '{
		rst: sys_rst,
		mode: latch_mode_strap,
		def: latch_default_strap,
		addr: address_strap_pins,
		rem_n: removal_request_in_n
	};

	// Every strap, removal request and reset pin is treated as asynchronous; bay_event_in bypasses this
	bslr_sync #(
		.W($bits(bslr_pins_type))
	) u_sync (
		.mclk(mclk),
		.d(pins_raw),
		.q(pins)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NBAYS; gi++) begin : g_deb
			bslr_debounce #(
				.TICKS(DEB_TICKS)
			) u_deb (
				.mclk(mclk),
				.rst(st.rst_q),
				.tick(st.tick),
				.din(pins.rem_n[gi]),
				.dout(rem_db[gi])
			);
		end
	endgenerate

	// Debounced request goes from released to asserted
	assign rem_fall = st.rem_prev & ~rem_db;

	// Reset value of the control bits from the straps
	assign ctl_reset = pins.mode ? '0 : {NBAYS{pins.def}};

	always_comb begin
		next_st = st;
		// Two consecutive high samples make the internal reset
		next_st.rst_prev = pins.rst;
		next_st.rst_q = pins.rst & st.rst_prev;

		// Millisecond tick from the reference clock
		next_st.tick = 1'b0;
		if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 1'b1;
		end

		next_st.slave_addr = {ADDR_HI, pins.addr};

		// Read data stands for one cycle only
		next_st.rdata = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				REG_STATUS: next_st.rdata = DW'(st.status);
				REG_MASK: next_st.rdata = DW'(st.mask);
				REG_CONTROL: next_st.rdata = DW'(st.ctl);
				REG_TIMING: next_st.rdata = DW'(st.timing);
				REG_INFO: next_st.rdata = {pins.mode, st.slave_addr};
				default: next_st.rdata = '0;
			endcase
		end

		if (bus_req.wr) begin
			case (bus_req.addr)
				REG_STATUS: next_st.status = st.status & ~bus_req.wdata[NEV-1:0];
				REG_MASK: next_st.mask = bus_req.wdata[NEV-1:0];
				REG_CONTROL: next_st.ctl = bus_req.wdata[NBAYS-1:0];
				REG_TIMING: next_st.timing = bus_req.wdata[1:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_st.status[EV_CHG_LSB +: NBAYS] = next_st.status[EV_CHG_LSB +: NBAYS]
			| bay_event_in;
		next_st.status[EV_REM_LSB +: NBAYS] = next_st.status[EV_REM_LSB +: NBAYS]
			| rem_fall;
		next_st.rem_prev = rem_db;

		next_st.ctl_prev = st.ctl;
		for (int i = 0; i < NBAYS; i++) begin
			// A new fall restarts a pulse already running
			if (pins.mode && st.ctl_prev[i] && !st.ctl[i]) begin
				next_st.pulse_cnt[i] = bslr_pulse_ticks(st.timing);
			end else if (st.tick && st.pulse_cnt[i] != '0) begin
				next_st.pulse_cnt[i] = st.pulse_cnt[i] - 1'b1;
			end
			// Enable high pulls the pin low; released means float
			if (pins.mode) begin
				next_st.drive_oe[i] = next_st.pulse_cnt[i] != '0;
			end else begin
				next_st.drive_oe[i] = ~st.ctl[i];
			end
		end
		next_st.drive_out = '0;

		next_st.irq_n = ~|(st.status & st.mask);

		if (st.rst_q) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b0;
			next_st.ctl = ctl_reset;
			next_st.ctl_prev = ctl_reset;
			next_st.status = '0;
			next_st.mask = MASK_RST;
			next_st.timing = TIMING_RST;
			next_st.pulse_cnt = '0;
			next_st.rem_prev = '1;
			next_st.drive_oe = pins.mode ? '0 : ~ctl_reset;
			next_st.irq_n = 1'b1;
			next_st.rdata = '0;
		end
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	assign rdata = st.rdata;
	assign latch_drive_out = st.drive_out;
	assign latch_drive_oe = st.drive_oe;
	assign irq_n = st.irq_n;
	assign slave_address = st.slave_addr;

	property p_irq_set;
		@(posedge mclk) disable iff (st.rst_q)
		|(st.status & st.mask) |=> !irq_n;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not low");

	property p_irq_clear;
		@(posedge mclk) disable iff (st.rst_q)
		(st.status & st.mask) == '0 |=> irq_n;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq not released");

	property p_w1c;
		@(posedge mclk) disable iff (st.rst_q)
		bus_req.wr && bus_req.addr == REG_STATUS && bus_req.wdata[EV_CHG_LSB]
			&& (st.status & st.mask) == NEV'(1) && bay_event_in == '0 && rem_fall == '0
			|=> !st.status[EV_CHG_LSB] ##1 irq_n;
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit not cleared");

	property p_set_wins;
		@(posedge mclk) disable iff (st.rst_q)
		bay_event_in[1] |=> st.status[EV_CHG_LSB + 1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");

	property p_addr;
		@(posedge mclk) disable iff (st.rst_q)
		!st.rst_q |=> slave_address == {ADDR_HI, $past(pins.addr)};
	endproperty
	a_addr: assert property (p_addr) else $error("bad slave address");

	property p_rst_pulse_mode;
		@(posedge mclk)
		st.rst_q && pins.mode |=> st.ctl == '0 && latch_drive_oe == '0;
	endproperty
	a_rst_pulse_mode: assert property (p_rst_pulse_mode) else $error("ctl not zero");

	property p_rst_level_mode;
		@(posedge mclk)
		st.rst_q && !pins.mode |=> st.ctl == {NBAYS{$past(pins.def)}};
	endproperty
	a_rst_level_mode: assert property (p_rst_level_mode) else $error("ctl default");

	property p_follow;
		@(posedge mclk) disable iff (st.rst_q)
		!pins.mode |=> latch_drive_oe == ~$past(st.ctl);
	endproperty
	a_follow: assert property (p_follow) else $error("drive not following");

	property p_pulse_start;
		@(posedge mclk) disable iff (st.rst_q)
		pins.mode && st.ctl_prev[0] && !st.ctl[0] |=> latch_drive_oe[0]
			&& st.pulse_cnt[0] == bslr_pulse_ticks($past(st.timing));
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("no pulse");

	property p_pulse_end;
		@(posedge mclk) disable iff (st.rst_q)
		pins.mode && st.tick && st.pulse_cnt[0] == 11'h001
			&& st.ctl_prev[0] == st.ctl[0] |=> !latch_drive_oe[0];
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");

	property p_deglitch;
		@(posedge mclk)
		pins.rst ##1 pins.rst |=> st.rst_q;
	endproperty
	a_deglitch: assert property (p_deglitch) else $error("reset missed");

	property p_glitch;
		@(posedge mclk)
		!pins.rst |=> !st.rst_q;
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch reset");

	property p_removal;
		@(posedge mclk) disable iff (st.rst_q)
		rem_fall[0] |=> st.status[EV_REM_LSB];
	endproperty
	a_removal: assert property (p_removal) else $error("removal lost");

	c_pulse: cover property (@(posedge mclk) st.ctl_prev[0] && !st.ctl[0] && pins.mode);
	c_irq: cover property (@(posedge mclk) $fell(irq_n));
	c_removal: cover property (@(posedge mclk) rem_fall != '0);
	c_reset: cover property (@(posedge mclk) $rose(st.rst_q));
endmodule
`default_nettype wire

// *** tb/bslr_host.sv ***
// Host model driving the register port of the bay logic
`timescale 1ns/100ps
`default_nettype none
module bslr_host (
	input wire logic mclk,
	input wire logic [bslr_pkg::DW-1:0] rdata,
	output var bslr_pkg::bslr_bus_req_type bus_req
);
	import bslr_pkg::*;
	initial bus_req = '0;
	// One-cycle write strobe; a one written to a status bit clears it
	task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus_req <= '0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic read(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		bus_req <= '0;
		@(negedge mclk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// *** tb/bslr_top_test.sv ***
// Self-checking bench for the bay strap, latch and reset logic
`timescale 1ns/100ps
`default_nettype none
module bslr_top_test;
	import bslr_pkg::*;
	localparam int TC = 10;
	localparam int DT = 2;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] strap_a = 2'h0;
	logic strap_def = 1'b0;
	logic strap_mode = 1'b0;
	logic [NBAYS-1:0] rem_n = 2'h3;
	logic [NBAYS-1:0] ev = 2'h0;
	bslr_bus_req_type bus_req;
	logic [DW-1:0] rdata;
	logic [NBAYS-1:0] drv_out;
	logic [NBAYS-1:0] drv_oe;
	logic irq_n;
	logic [6:0] saddr;
	wire logic [NBAYS-1:0] lock_pin;
	int err_total = 0;
	int check_count = 0;
	int seed = 26006;
	int n;
	logic [DW-1:0] rv;
	logic [DW-1:0] bit_v;
	// Pulled-up open-drain pins
	assign lock_pin = (drv_oe & drv_out) | ~drv_oe;
	initial forever #20 mclk = ~mclk;
	bslr_host i_bslr_host (.mclk(mclk), .rdata(rdata), .bus_req(bus_req));
	bslr_top #(.TICK_CYCLES(TC), .DEB_TICKS(DT)) i_bslr_top (
		.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
		.address_strap_pins(strap_a), .latch_default_strap(strap_def),
		.latch_mode_strap(strap_mode), .removal_request_in_n(rem_n),
		.bay_event_in(ev), .latch_drive_out(drv_out), .latch_drive_oe(drv_oe),
		.irq_n(irq_n), .slave_address(saddr));
	task automatic stop_test();
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_len(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, hi);
		end
	endtask
	task automatic do_reset(input int len);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (len) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(negedge mclk);
	endtask
	function automatic logic [1:0] exp_ctl(input logic m, input logic d);
		return m ? 2'h0 : {2{d}};
	endfunction
	function automatic int pulse_ms(input int s);
		case (s)
			0: return 120;
			1: return 500;
			2: return 1000;
			default: return 2000;
		endcase
	endfunction
	initial begin
		#(90000 * 40);
		err_total++;
		stop_test();
	end
	initial begin
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			strap_mode <= k[1];
			strap_def <= k[0];
			strap_a <= 2'($random(seed));
			do_reset(10);
			i_bslr_host.read(REG_CONTROL, rv);
			chk_val(rv, {6'h0, exp_ctl(strap_mode, strap_def)});
			chk_val({6'h0, drv_oe}, {6'h0, strap_mode ? 2'h0 : ~exp_ctl(1'b0, strap_def)});
			chk_val({1'b0, saddr}, {1'b0, 5'h12, strap_a});
			i_bslr_host.read(REG_INFO, rv);
			chk_val(rv, {strap_mode, 5'h12, strap_a});
			i_bslr_host.read(REG_MASK, rv);
			chk_val(rv, 8'h0f);
			chk_val({7'h0, irq_n}, 8'h01);
		end
		// A one-cycle glitch must not reset, two cycles must
		i_bslr_host.write(REG_MASK, 8'h00);
		do_reset(1);
		i_bslr_host.read(REG_MASK, rv);
		chk_val(rv, 8'h00);
		do_reset(2);
		i_bslr_host.read(REG_MASK, rv);
		chk_val(rv, 8'h0f);
		for (int a = 5; a < 16; a++) begin
			i_bslr_host.read(4'(a), rv);
			chk_val(rv, 8'h00);
		end
		@(posedge mclk);
		strap_mode <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			bit_v = 8'($random(seed));
			i_bslr_host.write(REG_CONTROL, bit_v);
			wait_cyc(4);
			chk_val({6'h0, lock_pin}, {6'h0, bit_v[1:0]});
		end
		@(posedge mclk);
		strap_mode <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			i_bslr_host.write(REG_TIMING, 8'(s));
			i_bslr_host.write(REG_CONTROL, 8'h03);
			i_bslr_host.write(REG_CONTROL, 8'h02);
			wait_cyc(3);
			chk_val({6'h0, lock_pin}, 8'h02);
			chk_val({6'h0, drv_out}, 8'h00);
			n = 0;
			while (drv_oe[0] === 1'b1 && n < 25000) begin
				@(negedge mclk);
				n++;
			end
			chk_len(n, (pulse_ms(s) - 1) * TC - 4, pulse_ms(s) * TC + 2);
		end
		for (int b = 0; b < 4; b++) begin
			bit_v = 8'h01 << b;
			@(posedge mclk);
			if (b < 2) begin
				ev[b] <= 1'b1;
				@(posedge mclk);
				ev <= 2'h0;
			end else begin
				// Short glitch filtered, then a held request
				rem_n[b - 2] <= 1'b0;
				repeat (3) @(posedge mclk);
				rem_n <= 2'h3;
				wait_cyc(40);
				chk_val({7'h0, irq_n}, 8'h01);
				@(posedge mclk);
				rem_n[b - 2] <= 1'b0;
			end
			n = 0;
			while (irq_n !== 1'b0 && n < 100) begin
				@(negedge mclk);
				n++;
			end
			chk_val({7'h0, irq_n}, 8'h00);
			i_bslr_host.read(REG_STATUS, rv);
			chk_val(rv, bit_v);
			i_bslr_host.write(REG_MASK, ~bit_v & 8'h0f);
			wait_cyc(3);
			chk_val({7'h0, irq_n}, 8'h01);
			i_bslr_host.write(REG_MASK, 8'h0f);
			wait_cyc(3);
			chk_val({7'h0, irq_n}, 8'h00);
			@(posedge mclk);
			rem_n <= 2'h3;
			wait_cyc(40);
			i_bslr_host.write(REG_STATUS, bit_v);
			wait_cyc(3);
			chk_val({7'h0, irq_n}, 8'h01);
			i_bslr_host.read(REG_STATUS, rv);
			chk_val(rv, 8'h00);
		end
		// Event and clear in one cycle: the event wins
		fork
			i_bslr_host.write(REG_STATUS, 8'h02);
			begin
				@(posedge mclk);
				ev[1] <= 1'b1;
				@(posedge mclk);
				ev <= 2'h0;
			end
		join
		i_bslr_host.read(REG_STATUS, rv);
		chk_val(rv, 8'h02);
		i_bslr_host.write(REG_STATUS, 8'h02);
		wait_cyc(3);
		chk_val({7'h0, irq_n}, 8'h01);
		stop_test();
	end
endmodule
`default_nettype wire
